// File: logic/iocrp_core.sv
// I/O cell register path with AHB-Lite configuration slave
// How it works
// - Input element is a rising-edge flop or high-transparent latch, clock invertible.
// - Init loads the configured value; low clock enable holds the element.
// - Storage elements reset to zero; init loads one only when set is selected.
// - An unconnected clock enable counts as high.
// - Flop mode captures only on the rising edge, otherwise holds.
// - Input delay: one tap default, or full, partial, none; skip removes it.
// - Each routing output picks direct pad input or the stored value.
// - Fast-capture latch runs on the output clock, not the input clock.
// - Capture latch is transparent low and feeds the input flop or latch.
// - Every clock of the fast-capture path is invertible inside the cell.
// - Output may be inverted, then sent direct or through the output flop.
// - Output flop inits, captures on rising edge; high-impedance request floats pad.
// - Low-voltage variant offers pass, AND, OR, XOR with optional inverted inputs.
// - In multiplexer mode the output clock selects between two outputs.
// - Function mode takes its critical operand through the output clock pin.
// - Input and output elements have separate, independently invertible clocks.
// - One clock enable, applied to input, output or both by configuration.
// - No user set or reset; reset clears to zero, init value serves the init pulse.
`include "iocrp_regs.svh"

module iocrp_core
    import iocrp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pad
    input  wire logic        padIn,
    output logic             padOut,
    output logic             padOutEn_n,
    // Fabric side
    input  wire logic        outData,
    input  wire logic        outDataB,
    input  wire logic        inputCaptureClock,
    input  wire logic        outputClock,
    input  wire logic        clockEnable,
    input  wire logic        hizReq,
    input  wire logic        globalInit,
    output logic             routeOutA,
    output logic             routeOutB
);

    // ---------------- Bus slave ----------------
    logic [31:0] ctrl;
    logic        wrPend;
    logic [`IOCRP_ADDR_W-1:0] wrAddr;
    logic        swInit;

    wire addrPhase = hsel & hready & htrans[1];
    wire [`IOCRP_ADDR_W-1:0] decAddr = haddr[`IOCRP_ADDR_W-1:0];
    wire mappedWord = (haddr[31:`IOCRP_ADDR_W] == '0);
    wire wrCtrl = wrPend & (wrAddr == `IOCRP_OFS_CTRL);
    wire wrInit = wrPend & (wrAddr == `IOCRP_OFS_INIT);
    wire [31:0] statusWord;
    wire [31:0] next_hrdata =
        !mappedWord                        ? 32'h0000_0000 :
        (decAddr == `IOCRP_OFS_CTRL)       ? ctrl :
        (decAddr == `IOCRP_OFS_STATUS)     ? statusWord :
        32'h0000_0000;

    // Zero wait states; unmapped reads return zero, writes are dropped
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend <= 1'b0;
            wrAddr <= `IOCRP_OFS_CTRL;
        end else begin
            wrPend <= addrPhase & hwrite & mappedWord;
            wrAddr <= decAddr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase & ~hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // static settings
    // Fields take effect at once; software should write only while idle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `IOCRP_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl <= hwdata & `IOCRP_CTRL_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            swInit <= 1'b0;
        end else begin
            swInit <= wrInit & hwdata[`IOCRP_I_PULSE];
        end
    end

    // ---------------- Configuration decode ----------------
    iocrp_cfg_t cfg;
    assign cfg.lowVolt        = ctrl[`IOCRP_C_VARIANT];
    assign cfg.inMode         = iocrp_inmode_t'(ctrl[`IOCRP_C_INMODE_HI:`IOCRP_C_INMODE_LO]);
    assign cfg.inClkInv       = ctrl[`IOCRP_C_INCLKINV];
    assign cfg.outClkInv      = ctrl[`IOCRP_C_OUTCLKINV];
    assign cfg.capClkInv      = ctrl[`IOCRP_C_CAPCLKINV];
    assign cfg.delaySel       = iocrp_delay_t'(ctrl[`IOCRP_C_DLY_HI:`IOCRP_C_DLY_LO]);
    assign cfg.skipInputDelay = ctrl[`IOCRP_C_SKIPDLY];
    assign cfg.routeASel      = ctrl[`IOCRP_C_ROUTEA];
    assign cfg.routeBSel      = ctrl[`IOCRP_C_ROUTEB];
    assign cfg.outInv         = ctrl[`IOCRP_C_OUTINV];
    assign cfg.outReg         = ctrl[`IOCRP_C_OUTREG];
    assign cfg.ecSkipIn       = ctrl[`IOCRP_C_ECSKIPIN];
    assign cfg.ecSkipOut      = ctrl[`IOCRP_C_ECSKIPOUT];
    assign cfg.inSet          = ctrl[`IOCRP_C_INSET];
    assign cfg.outSet         = ctrl[`IOCRP_C_OUTSET];
    assign cfg.ecFloat        = ctrl[`IOCRP_C_ECFLOAT];
    assign cfg.hizFloat       = ctrl[`IOCRP_C_HIZFLOAT];
    assign cfg.func           = iocrp_func_t'(ctrl[`IOCRP_C_FN_HI:`IOCRP_C_FN_LO]);
    assign cfg.fnInvA         = ctrl[`IOCRP_C_FNINVA];
    assign cfg.fnInvF         = ctrl[`IOCRP_C_FNINVF];

    // ---------------- Shared controls ----------------
    // the global init pin or the software init pulse sets or clears the elements
    wire initPulse = globalInit | swInit;

    wire ecEff = cfg.ecFloat | clockEnable;

    // enable steered to input, output or both, never inverted
    wire inEn  = cfg.ecSkipIn | ecEff;
    wire outEn = cfg.ecSkipOut | ecEff;

    // separate clocks, each with its own inversion
    wire inClk  = inputCaptureClock ^ cfg.inClkInv;
    wire outClk = outputClock ^ cfg.outClkInv;

    // ---------------- Input delay ----------------
    logic [`IOCRP_TAPS-1:0] tap;

    // delay taps modelled as clk stages
    genvar gi;
    generate
        for (gi = 0; gi < `IOCRP_TAPS; gi = gi + 1) begin : g_tap
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tap[gi] <= 1'b0;
                end else begin
                    tap[gi] <= (gi == 0) ? padIn : tap[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    // one tap on the 5 V variant, full/partial/none on the 3.3 V one
    wire lvDelayed = (cfg.delaySel == DLY_FULL) ? tap[`IOCRP_TAPS-1] :
                     (cfg.delaySel == DLY_PART) ? tap[0] : padIn;
    wire hvDelayed = tap[0];
    wire padDelayed = cfg.skipInputDelay ? padIn :
                      (cfg.lowVolt ? lvDelayed : hvDelayed);

    // ---------------- Fast-capture latch ----------------
    // capture latch clocked from the output clock pin
    // its clock has a private inverter
    // transparent while its clock is low
    wire capClkLow = ~(outputClock ^ cfg.capClkInv);
    wire capUsed = cfg.lowVolt &
                   ((cfg.inMode == IN_CAP_FLOP) | (cfg.inMode == IN_CAP_LATCH));
    iocrp_store_in_t capCtl;
    logic            capQ;

    // init value applies to the capture stage as well
    assign capCtl.clk       = capClkLow;
    assign capCtl.en        = 1'b1;
    assign capCtl.init      = initPulse;
    assign capCtl.initVal   = cfg.inSet;
    assign capCtl.latchMode = 1'b1;
    assign capCtl.d         = padDelayed;

    iocrp_store u_capture (
        .clk (clk),
        .rst (rst),
        .ctl (capCtl),
        .q   (capQ)
    );

    // ---------------- Input storage element ----------------
    // flop or latch chosen per mode; capture modes need the 3.3 V variant
    // after the capture latch comes a flop or a high-transparent latch
    wire inLatch = (cfg.inMode == IN_LATCH) | (cfg.inMode == IN_CAP_LATCH);
    iocrp_store_in_t inCtl;
    logic            inQ;

    // init value loads regardless of clock, enable or data
    assign inCtl.clk       = inClk;
    assign inCtl.en        = inEn;
    assign inCtl.init      = initPulse;
    assign inCtl.initVal   = cfg.inSet;
    // edge mode captures on the rising edge only
    assign inCtl.latchMode = inLatch;
    assign inCtl.d         = capUsed ? capQ : padDelayed;

    iocrp_store u_input (
        .clk (clk),
        .rst (rst),
        .ctl (inCtl),
        .q   (inQ)
    );

    // each routing output picks direct or stored input
    wire next_routeA = cfg.routeASel ? inQ : padIn;
    wire next_routeB = cfg.routeBSel ? inQ : padIn;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            routeOutA <= 1'b0;
            routeOutB <= 1'b0;
        end else begin
            routeOutA <= next_routeA;
            routeOutB <= next_routeB;
        end
    end

    // ---------------- Output path ----------------
    // optional inversion before the flop or the buffer
    wire outSrc = outData ^ cfg.outInv;
    iocrp_store_in_t outCtl;
    logic            outQ;

    // init, rising-edge capture when enabled, hold otherwise
    assign outCtl.clk       = outClk;
    assign outCtl.en        = outEn;
    assign outCtl.init      = initPulse;
    assign outCtl.initVal   = cfg.outSet;
    assign outCtl.latchMode = 1'b0;
    assign outCtl.d         = outSrc;

    iocrp_store u_output (
        .clk (clk),
        .rst (rst),
        .ctl (outCtl),
        .q   (outQ)
    );

    wire outPath = cfg.outReg ? outQ : outSrc;

    // critical operand is the output clock pin
    wire fnA = outPath ^ cfg.fnInvA;
    wire fnF = outputClock ^ cfg.fnInvF;
    logic fnOut;

    // function of fnA and fnF; in mux mode the output clock selects between the two outputs
    always_comb begin
        case (cfg.func)
            FN_PASS: fnOut = fnA;
            FN_AND:  fnOut = fnA & fnF;
            FN_OR:   fnOut = fnA | fnF;
            FN_XOR:  fnOut = fnA ^ fnF;
            FN_MUX:  fnOut = outputClock ? outDataB : outPath;
            default: fnOut = fnA;
        endcase
    end

    // The 5 V variant has no function element in its output path
    wire next_padOut = cfg.lowVolt ? fnOut : outPath;

    // open hiz request counts as low
    wire hizEff = ~cfg.hizFloat & hizReq;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            padOut     <= 1'b0;
            padOutEn_n <= 1'b1;
        end else begin
            padOut     <= next_padOut;
            padOutEn_n <= hizEff;
        end
    end

    // ---------------- Status ----------------
    assign statusWord = {24'h000000,
                         padOutEn_n, padOut, routeOutB, routeOutA,
                         outQ, inQ, capQ, padIn};

    // hsize is accepted as word only; narrower sizes act as word access
    wire unusedSize = ^hsize;

endmodule

// File: logic/iocrp_regs.svh
// Register offsets, field positions and reset values of the I/O cell
`ifndef IOCRP_REGS_SVH
`define IOCRP_REGS_SVH

`define IOCRP_ADDR_W        4
`define IOCRP_OFS_CTRL      4'h0
`define IOCRP_OFS_STATUS    4'h4
`define IOCRP_OFS_INIT      4'h8
`define IOCRP_CTRL_RST      32'h0000_0000

// CTRL fields
`define IOCRP_C_VARIANT     0
`define IOCRP_C_INMODE_LO   1
`define IOCRP_C_INMODE_HI   2
`define IOCRP_C_INCLKINV    3
`define IOCRP_C_OUTCLKINV   4
`define IOCRP_C_CAPCLKINV   5
`define IOCRP_C_DLY_LO      6
`define IOCRP_C_DLY_HI      7
`define IOCRP_C_SKIPDLY     8
`define IOCRP_C_ROUTEA      9
`define IOCRP_C_ROUTEB      10
`define IOCRP_C_OUTINV      11
`define IOCRP_C_OUTREG      12
`define IOCRP_C_ECSKIPIN    13
`define IOCRP_C_ECSKIPOUT   14
`define IOCRP_C_INSET       15
`define IOCRP_C_OUTSET      16
`define IOCRP_C_ECFLOAT     17
`define IOCRP_C_HIZFLOAT    18
`define IOCRP_C_FN_LO       19
`define IOCRP_C_FN_HI       21
`define IOCRP_C_FNINVA      22
`define IOCRP_C_FNINVF      23
`define IOCRP_CTRL_MASK     32'h00FF_FFFF

// STATUS fields
`define IOCRP_S_PADIN       0
`define IOCRP_S_CAPQ        1
`define IOCRP_S_INQ         2
`define IOCRP_S_OUTQ        3
`define IOCRP_S_ROUTEA      4
`define IOCRP_S_ROUTEB      5
`define IOCRP_S_PADOUT      6
`define IOCRP_S_PADOEN      7

// INIT fields
`define IOCRP_I_PULSE       0

// Input delay taps of the larger variant
`define IOCRP_TAPS          2

`endif

// File: logic/iocrp_pkg.sv
// Types shared by the I/O cell register path
package iocrp_pkg;

    typedef enum logic [1:0] {
        IN_FLOP,
        IN_LATCH,
        IN_CAP_FLOP,
        IN_CAP_LATCH
    } iocrp_inmode_t;

    typedef enum logic [1:0] {
        DLY_FULL,
        DLY_PART,
        DLY_NONE,
        DLY_NONE_ALT
    } iocrp_delay_t;

    typedef enum logic [2:0] {
        FN_PASS,
        FN_AND,
        FN_OR,
        FN_XOR,
        FN_MUX,
        FN_RSV5,
        FN_RSV6,
        FN_RSV7
    } iocrp_func_t;

    typedef struct packed {
        logic          lowVolt;
        iocrp_inmode_t inMode;
        logic          inClkInv;
        logic          outClkInv;
        logic          capClkInv;
        iocrp_delay_t  delaySel;
        logic          skipInputDelay;
        logic          routeASel;
        logic          routeBSel;
        logic          outInv;
        logic          outReg;
        logic          ecSkipIn;
        logic          ecSkipOut;
        logic          inSet;
        logic          outSet;
        logic          ecFloat;
        logic          hizFloat;
        iocrp_func_t   func;
        logic          fnInvA;
        logic          fnInvF;
    } iocrp_cfg_t;

    typedef struct packed {
        logic clk;
        logic en;
        logic init;
        logic initVal;
        logic latchMode;
        logic d;
    } iocrp_store_in_t;

endpackage

// File: logic/iocrp_store.sv
// One storage element: edge flip-flop or level latch, sampled on clk
`include "iocrp_regs.svh"

module iocrp_store
    import iocrp_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Element controls
    input  wire iocrp_store_in_t ctl,
    // Stored value
    output logic                 q
);

    logic prevClk;
    wire  rise   = ctl.clk & ~prevClk;
    wire  loadEn = ctl.en & (ctl.latchMode ? ctl.clk : rise);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevClk <= 1'b0;
        end else begin
            prevClk <= ctl.clk;
        end
    end

    // Init wins over clock and enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (ctl.init) begin
            q <= ctl.initVal;
        end else if (loadEn) begin
            q <= ctl.d;
        end
    end

endmodule

// File: tb/iocrp_core_asserts.sv
// Concurrent checks on the I/O cell register path ports
`include "iocrp_regs.svh"

module iocrp_core_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Pad and fabric
    input wire logic        padIn,
    input wire logic        padOut,
    input wire logic        padOutEn_n,
    input wire logic        outData,
    input wire logic        inputCaptureClock,
    input wire logic        clockEnable,
    input wire logic        hizReq,
    input wire logic        globalInit,
    input wire logic        routeOutA
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ctrl;
    logic        wrPend;
    wire         take = hsel && hready && htrans[1];
    wire         ceOn = clockEnable || ctrl[17] || ctrl[13];
    // Shadow of the mode word, so checks know the mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend <= 1'b0;
            ctrl   <= 32'h0;
        end else begin
            wrPend <= take && hwrite && haddr == {28'h0, `IOCRP_OFS_CTRL};
            if (wrPend)
                ctrl <= hwdata & `IOCRP_CTRL_MASK;
        end
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_bus;
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus stalled or error");
    property p_hiz;
        hizReq && !ctrl[18] |=> padOutEn_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pad not released");
    property p_drive;
        (!hizReq || ctrl[18]) |=> !padOutEn_n;
    endproperty
    a_drive: assert property (p_drive) else $error("pad not driven");
    property p_direct;
        !ctrl[0] && !ctrl[12] && !wrPend |=> padOut == ($past(outData) ^ ctrl[11]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct output wrong");
    property p_route;
        !ctrl[9] && ctrl[8] |=> routeOutA == $past(padIn);
    endproperty
    a_route: assert property (p_route) else $error("direct route wrong");
    // Flop mode, plain clock, no delay, stored value routed
    property p_flop;
        $rose(inputCaptureClock) && !globalInit && ctrl[2:1] == 2'h0 && !ctrl[3]
            && ctrl[8] && ctrl[9] && ceOn && !wrPend |=> ##1 routeOutA == $past(padIn, 2);
    endproperty
    a_flop: assert property (p_flop) else $error("flop capture wrong");
    property p_hold;
        !ceOn && !globalInit && ctrl[9] && !wrPend |=> ##1 $stable(routeOutA);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled element moved");
    property p_init;
        globalInit && ctrl[9] && !wrPend ##1 globalInit && !wrPend |=> routeOutA == ctrl[15];
    endproperty
    a_init: assert property (p_init) else $error("init value wrong");
    property p_rd0;
        take && !hwrite && (haddr[31:4] != 28'h0 || haddr[3]) |=> hrdata == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("unreadable place not zero");
endmodule

bind iocrp_core iocrp_core_asserts u_chk (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .padIn(padIn), .padOut(padOut), .padOutEn_n(padOutEn_n),
    .outData(outData), .inputCaptureClock(inputCaptureClock), .clockEnable(clockEnable),
    .hizReq(hizReq), .globalInit(globalInit), .routeOutA(routeOutA)
);

// File: tb/iocrp_pad_dev.sv
// Far-side pad device: drives the pad only while the cell lets go
module iocrp_pad_dev (
    // Cell side
    input  wire logic padOut,
    input  wire logic padOutEn_n,
    // Level this device drives
    input  wire logic drv,
    output logic      padIn
);
    timeunit 1ns;
    timeprecision 100ps;
    assign padIn = padOutEn_n ? drv : padOut;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the I/O cell register path
`include "iocrp_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, padIn, padOut, padOutEn_n;
    logic        outData, outDataB, icc, oc, ce, hiz, gi, drv, routeOutA, routeOutB;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, seed, r;
    int          bad_count, n_checks;

    iocrp_core dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .padIn(padIn), .padOut(padOut),
        .padOutEn_n(padOutEn_n), .outData(outData), .outDataB(outDataB),
        .inputCaptureClock(icc), .outputClock(oc), .clockEnable(ce), .hizReq(hiz),
        .globalInit(gi), .routeOutA(routeOutA), .routeOutB(routeOutB)
    );
    iocrp_pad_dev pad (.padOut(padOut), .padOutEn_n(padOutEn_n), .drv(drv), .padIn(padIn));

    always #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Next stored value: init wins, then enabled edge or open latch
    function automatic logic nxt(logic q, g, s, lat, k, pk, e, d);
        if (g)
            return s;
        if (e && k && (lat || !pk))
            return d;
        return q;
    endfunction
    function automatic logic fexp(logic [4:0] c, logic [31:0] x);
        logic a;
        logic f;
        a = x[0] ^ c[3];
        f = x[2] ^ c[4];
        case (c[2:0])
            3'h1: return a & f;
            3'h2: return a | f;
            3'h3: return a ^ f;
            // Mux passes data and select without the operand inverters
            3'h4: return x[2] ? x[1] : x[0];
            default: return a;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] rv);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rv = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0, r);
        chk("hrdata", e, r);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [4:0]  c;
        logic [31:0] x;
        logic [4:0]  h;
        logic [2:0]  qa, qo;
        logic        pi, po, g;
        int          lat [6];
        logic [31:0] dcf [6];
        // Stored route through open latches, enable tied: delay taps plus two, plus one for the capture latch
        lat = '{3, 2, 4, 3, 2, 3};
        dcf = '{32'h2020A, 32'h2030A, 32'h2020B, 32'h2024B, 32'h2028B, 32'h2030F};
        {clk, hsel, hwrite, htrans, haddr, hwdata, outData, outDataB} = '0;
        {icc, oc, ce, hiz, gi, drv, h, qa, qo} = '0;
        rst = 1'b1;
        seed = 32'h705C;
        bad_count = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`IOCRP_OFS_CTRL, 32'h0);
        // Quiet pad after reset: every status bit low
        rdc(`IOCRP_OFS_STATUS, 32'h0);
        bus(1'b1, 32'h10, 32'hFFFF_FFFF, r);
        rdc(32'h10, 32'h0);
        rdc(`IOCRP_OFS_INIT, 32'h0);
        repeat (6) begin
            x = rnd();
            bus(1'b1, `IOCRP_OFS_CTRL, x, r);
            rdc(`IOCRP_OFS_CTRL, x & `IOCRP_CTRL_MASK);
        end
        // Pad released so the far side feeds the input path
        hiz <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, `IOCRP_OFS_CTRL, dcf[k], r);
            for (int n = 0; n < 12; n++) begin
                @(posedge clk);
                x = rnd();
                drv <= x[0];
                h = {h[3:0], x[0]};
                #1;
                if (n > 3) chk("routeOutA", h[lat[k]], routeOutA);
                if (n > 3) chk("routeOutB", h[1], routeOutB);
            end
        end
        hiz <= 1'b0;
        for (int k = 0; k < 32; k++) begin
            c = k[4:0];
            // Skip delay set so the direct route check also sees traffic
            bus(1'b1, `IOCRP_OFS_CTRL, {8'h0, c[4:3], c[2:0], 19'h101}, r);
            repeat (4) begin
                @(posedge clk);
                x = rnd();
                outData <= x[0];
                outDataB <= x[1];
                oc <= x[2];
                @(posedge clk);
                #1;
                chk("padOut", fexp(c, x), padOut);
                chk("padOutEn_n", 0, padOutEn_n);
            end
        end
        hiz <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            c = k[4:0];
            bus(1'b1, `IOCRP_OFS_CTRL, 32'h1300 | c[0] << 1 | c[3] << 3 | c[3] << 4
                | c[1] << 15 | c[1] << 16 | c[2] << 17, r);
            pi = icc ^ c[3];
            po = oc ^ c[3];
            for (int n = 0; n < 30; n++) begin
                @(posedge clk);
                x = rnd();
                g = x[6:4] == 3'h0 || n == 0;
                drv <= x[0];
                icc <= x[1];
                oc <= x[2];
                ce <= x[3];
                gi <= g;
                outData <= x[7];
                qa = {qa[1:0], nxt(qa[0], g, c[1], c[0], x[1] ^ c[3], pi, x[3] | c[2], x[0])};
                qo = {qo[1:0], nxt(qo[0], g, c[1], 1'b0, x[2] ^ c[3], po, x[3] | c[2], x[7])};
                pi = x[1] ^ c[3];
                po = x[2] ^ c[3];
                #1;
                if (n > 2) chk("routeOutA", qa[2], routeOutA);
                if (n > 2) chk("padOut", qo[2], padOut);
                if (n > 2) chk("padOutEn_n", 1, padOutEn_n);
            end
        end
        wrap_up();
    end
endmodule
